// ===== prf_defs.svh
// Overview of operation
// [RULE_01] 32-bit upper-node physical filter plus remote-bus bit
// [RULE_02] check async filters first, then this filter
// [RULE_03] clear bit sends request to async context
// [RULE_04] per-node compare only for local-bus sources
// [RULE_05] remote-bus packets unacknowledged unless bit 31 set
// [RULE_06] bit 31 set accepts all remote-bus requests
// [RULE_07] bit n enables local node n+32
// [RULE_08] set at 110h, clear at 114h, reset zero
// [RULE_09] low filter covers nodes 0 to 31
// [RULE_10] write ones set/clear; reads return filter
`ifndef PRF_DEFS_SVH
`define PRF_DEFS_SVH

// register byte offsets on the wishbone bus
`define PRF_ASYNC_HI_SET    12'h100
`define PRF_ASYNC_HI_CLR    12'h104
`define PRF_ASYNC_LO_SET    12'h108
`define PRF_ASYNC_LO_CLR    12'h10c
`define PRF_PHYS_HI_SET     12'h110
`define PRF_PHYS_HI_CLR     12'h114
`define PRF_PHYS_LO_SET     12'h118
`define PRF_PHYS_LO_CLR     12'h11c
`define PRF_PHYS_UPPER      12'h120

// filter reset value
`define PRF_FILTER_RST      32'h0000_0000

// field positions in the high filters
`define PRF_ALL_BUS_BIT     5'd31
`define PRF_HI_NODE_BASE    6'h20
`define PRF_BROADCAST_NODE  6'h3f

// bus id meaning "this bus"
`define PRF_LOCAL_BUS_ALIAS 10'h3ff

`endif

// ===== prf_pkg.sv
package prf_pkg;

    // source of an incoming request packet
    typedef struct packed {
        logic [9:0] bus_id;   // source bus number
        logic [5:0] node_id;  // source physical node number
    } prf_src_s;

    // routing outcome of one request
    typedef enum logic [1:0] {
        PRF_TO_PHYSICAL,
        PRF_TO_ASYNC,
        PRF_NO_ACK
    } prf_route_e;

    // registered decision handed to the receive logic
    typedef struct packed {
        prf_route_e route;   // where the packet goes
        prf_src_s   src;     // echo of the source
    } prf_decision_s;

    // snapshot of the four filters
    typedef struct packed {
        logic [31:0] async_hi;
        logic [31:0] async_lo;
        logic [31:0] phys_hi;
        logic [31:0] phys_lo;
    } prf_filters_s;

endpackage

// ===== prf_route.sv
`timescale 1ns/1ns
`include "prf_defs.svh"

module prf_route
(
    // request source and bus identity
    input  wire prf_pkg::prf_src_s     src_i,
    input  wire logic [9:0]            local_bus_id_i,
    // current filter contents
    input  wire prf_pkg::prf_filters_s filt_i,
    // routing outcome
    output prf_pkg::prf_route_e        route_o
);

    // picks a node's bit out of a low/high filter pair
    function automatic logic node_bit(input logic [31:0] lo, input logic [31:0] hi,
                                      input logic [5:0] node);
        logic [5:0] idx;
        idx = node - `PRF_HI_NODE_BASE;
        if (node == `PRF_BROADCAST_NODE)
            node_bit = 1'b0;                       // no filter bit for broadcast
        else if (node < `PRF_HI_NODE_BASE)
            node_bit = lo[node[4:0]];              // RULE_09
        else
            node_bit = hi[idx[4:0]];               // RULE_07
    endfunction

    logic is_local;   // source on our own bus
    logic async_ok;   // async filter admits node
    logic phys_ok;    // physical filter admits node

    // routing decision
    always_comb
    begin
        is_local = (src_i.bus_id == `PRF_LOCAL_BUS_ALIAS) || (src_i.bus_id == local_bus_id_i);
        async_ok = node_bit(filt_i.async_lo, filt_i.async_hi, src_i.node_id);
        phys_ok  = node_bit(filt_i.phys_lo, filt_i.phys_hi, src_i.node_id);
        if (!is_local)
        begin
            // remote bus: only the all-buses bit matters
            if (filt_i.phys_hi[`PRF_ALL_BUS_BIT])
                route_o = prf_pkg::PRF_TO_PHYSICAL;   // RULE_06
            else
                route_o = prf_pkg::PRF_NO_ACK;        // RULE_05
        end
        else if (!async_ok)
            route_o = prf_pkg::PRF_NO_ACK;            // RULE_02
        else if (phys_ok)
            route_o = prf_pkg::PRF_TO_PHYSICAL;       // RULE_04
        else
            route_o = prf_pkg::PRF_TO_ASYNC;          // RULE_03
    end

endmodule // prf_route

// ===== prf_filter.sv
`timescale 1ns/1ns
`include "prf_defs.svh"

module prf_filter
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone classic slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [11:0]            adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic [31:0]                 dat_o,
    output logic                        ack_o,
    // incoming physical request from the receiver
    input  wire logic                   req_valid_i,
    input  wire prf_pkg::prf_src_s      req_src_i,
    input  wire logic [9:0]             local_bus_id_i,
    // routing decision
    output logic                        dec_valid_o,
    output prf_pkg::prf_decision_s      dec_o,
    // live physical high filter contents
    output logic [31:0]                 phys_hi_o
);

    // decoded register access
    typedef struct packed {
        logic       hit;     // mapped filter offset
        logic [1:0] idx;     // which filter
        logic       clr;     // clear half of the pair
        logic       zero;    // reads-as-zero register
    } prf_dec_s;

    // address decode, used for read and write
    function automatic prf_dec_s decode(input logic [11:0] a);
        prf_dec_s d;
        d = '0;
        unique case (a)
            `PRF_ASYNC_HI_SET: d = '{1'b1, 2'd0, 1'b0, 1'b0};
            `PRF_ASYNC_HI_CLR: d = '{1'b1, 2'd0, 1'b1, 1'b0};
            `PRF_ASYNC_LO_SET: d = '{1'b1, 2'd1, 1'b0, 1'b0};
            `PRF_ASYNC_LO_CLR: d = '{1'b1, 2'd1, 1'b1, 1'b0};
            `PRF_PHYS_HI_SET:  d = '{1'b1, 2'd2, 1'b0, 1'b0}; // RULE_08
            `PRF_PHYS_HI_CLR:  d = '{1'b1, 2'd2, 1'b1, 1'b0}; // RULE_08
            `PRF_PHYS_LO_SET:  d = '{1'b1, 2'd3, 1'b0, 1'b0};
            `PRF_PHYS_LO_CLR:  d = '{1'b1, 2'd3, 1'b1, 1'b0};
            `PRF_PHYS_UPPER:   d = '{1'b0, 2'd0, 1'b0, 1'b1};
            default:           d = '0;
        endcase
        decode = d;
    endfunction

    // byte enables widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // filter storage: async hi/lo, physical hi/lo
    logic [31:0] filt_q [4];
    logic [31:0] filt_d [4];
    // bus answer
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    // routing decision
    logic                   dv_q;
    logic                   dv_d;
    prf_pkg::prf_decision_s dec_q;
    prf_pkg::prf_decision_s dec_d;
    // helpers
    prf_dec_s               acc;       // current access decode
    logic                   take;      // bus access taken this edge
    logic [31:0]            wmask;     // ones written, per lane
    prf_pkg::prf_filters_s  filt_all;  // filters for the router
    prf_pkg::prf_route_e    route;     // router answer

    // an access is answered one edge after it appears
    assign take = cyc_i & stb_i & ~ack_q;
    assign acc  = decode(adr_i);
    assign wmask = dat_i & lane_mask(sel_i);

    // register next values
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            filt_d[i] = filt_q[i];
        // writing ones sets or clears, zeros leave bits alone
        if (take && we_i && acc.hit)
        begin
            if (acc.clr)
                filt_d[acc.idx] = filt_q[acc.idx] & ~wmask;   // RULE_10
            else
                filt_d[acc.idx] = filt_q[acc.idx] | wmask;    // RULE_10
        end
    end

    // filter flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 4; i++)
                filt_q[i] <= `PRF_FILTER_RST;                 // RULE_08
        end
        else
        begin
            for (int i = 0; i < 4; i++)
                filt_q[i] <= filt_d[i];
        end
    end

    // bus answer next values
    always_comb
    begin
        ack_d  = take;
        rdat_d = rdat_q;
        if (take)
        begin
            // either offset of a pair reads the filter
            if (acc.hit && !we_i)
                rdat_d = filt_q[acc.idx];                     // RULE_10
            else
                rdat_d = 32'h0000_0000;   // writes, upper bound, unmapped
        end
    end

    // bus answer flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // filter contents gathered for routing
    always_comb
    begin
        filt_all.async_hi = filt_q[0];
        filt_all.async_lo = filt_q[1];
        filt_all.phys_hi  = filt_q[2];                        // RULE_01
        filt_all.phys_lo  = filt_q[3];
    end

    // per-packet router
    prf_route u_route
    (
        .src_i          (req_src_i),
        .local_bus_id_i (local_bus_id_i),
        .filt_i         (filt_all),
        .route_o        (route)
    );

    // decision next values
    always_comb
    begin
        dv_d  = req_valid_i;
        dec_d = dec_q;
        if (req_valid_i)
        begin
            dec_d.route = route;                              // RULE_02
            dec_d.src   = req_src_i;
        end
    end

    // decision flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dv_q  <= 1'b0;
            dec_q <= '{prf_pkg::PRF_NO_ACK, 16'h0000};
        end
        else
        begin
            dv_q  <= dv_d;
            dec_q <= dec_d;
        end
    end

    // outputs
    assign ack_o       = ack_q;
    assign dat_o       = rdat_q;
    assign dec_valid_o = dv_q;
    assign dec_o       = dec_q;
    assign phys_hi_o   = filt_q[2];

endmodule // prf_filter

// ===== prf_filter_assertions.sv
`timescale 1ns/1ns
`include "prf_defs.svh"

module prf_filter_assertions
(
    // clock and reset
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    // wishbone side
    input wire logic                   cyc_i,
    input wire logic                   stb_i,
    input wire logic                   we_i,
    input wire logic [11:0]            adr_i,
    input wire logic [3:0]             sel_i,
    input wire logic [31:0]            dat_i,
    input wire logic                   ack_o,
    // request and decision side
    input wire logic                   req_valid_i,
    input wire prf_pkg::prf_src_s      req_src_i,
    input wire logic [9:0]             local_bus_id_i,
    input wire logic                   dec_valid_o,
    input wire prf_pkg::prf_decision_s dec_o,
    input wire logic [31:0]            phys_hi_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr;  // full-word write being taken
    logic loc; // source on our own bus
    logic hi;  // source is an upper node with a bit
    assign wr  = cyc_i & stb_i & ~ack_o & we_i & (sel_i == 4'hf);
    assign loc = (req_src_i.bus_id == local_bus_id_i) | (req_src_i.bus_id == `PRF_LOCAL_BUS_ALIAS);
    assign hi  = loc & req_src_i.node_id[5] & (req_src_i.node_id != 6'h3f);
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_dec_next: assert property (req_valid_i |=> dec_valid_o && dec_o.src == $past(req_src_i))
        else $error("decision missing");
    a_dec_cause: assert property (dec_valid_o |-> $past(req_valid_i))
        else $error("decision without request");
    a_set_ones: assert property (wr && adr_i == `PRF_PHYS_HI_SET
        |=> phys_hi_o == ($past(phys_hi_o) | $past(dat_i))) else $error("set failed");
    a_clr_ones: assert property (wr && adr_i == `PRF_PHYS_HI_CLR
        |=> phys_hi_o == ($past(phys_hi_o) & ~$past(dat_i))) else $error("clear failed");
    a_rst_zero: assert property ($fell(rst_i) |-> phys_hi_o == 32'h0)
        else $error("filter not cleared");
    a_remote_drop: assert property (req_valid_i && !loc && !phys_hi_o[31]
        |=> dec_o.route == prf_pkg::PRF_NO_ACK) else $error("remote acked");
    a_remote_pass: assert property (req_valid_i && !loc && phys_hi_o[31]
        |=> dec_o.route == prf_pkg::PRF_TO_PHYSICAL) else $error("remote refused");
    a_node_clear: assert property (req_valid_i && hi && !phys_hi_o[req_src_i.node_id[4:0]]
        |=> dec_o.route != prf_pkg::PRF_TO_PHYSICAL) else $error("clear bit physical");
    a_node_set: assert property (req_valid_i && hi && phys_hi_o[req_src_i.node_id[4:0]]
        |=> dec_o.route != prf_pkg::PRF_TO_ASYNC) else $error("set bit async");
    c_remote: cover property (req_valid_i && !loc && phys_hi_o[31]);
    c_node_hi: cover property (req_valid_i && hi);
    c_write: cover property (wr && adr_i == `PRF_PHYS_HI_SET);
endmodule // prf_filter_assertions

bind prf_filter prf_filter_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .req_valid_i(req_valid_i), .req_src_i(req_src_i), .local_bus_id_i(local_bus_id_i),
    .dec_valid_o(dec_valid_o), .dec_o(dec_o), .phys_hi_o(phys_hi_o));

// ===== prf_node_model.sv
`timescale 1ns/1ns

module prf_node_model
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // command from the bench
    input  wire logic              send_i,
    input  wire prf_pkg::prf_src_s src_i,
    // request toward the filter
    output logic                   req_valid_o,
    output prf_pkg::prf_src_s      req_src_o
);
    logic              v_d; // next strobe
    prf_pkg::prf_src_s s_d; // next source
    // idle source lines show a changing pattern
    always_comb
    begin
        v_d = send_i;
        s_d = send_i ? src_i : ~req_src_o;
    end
    // register one request per command
    always_ff @(posedge clk_i)
    begin
        req_valid_o <= rst_i ? 1'b0 : v_d;
        req_src_o   <= rst_i ? '0 : s_d;
    end
endmodule // prf_node_model

// ===== prf_tb_top.sv
`timescale 1ns/1ns

module physical_request_filter_high_tb_top;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, send = 0;
    logic [11:0] adr_i = 0;
    logic [31:0] dat_i = 0, dat_o, phys_hi_o, m, rd, d;
    // async high and physical low filter models, lane-masked write data
    logic [31:0] a = 32'hffff_ffff, l = 32'h0, dm;
    // byte enables for the next bus cycle
    logic [3:0] sel_i = 4'hf, sl = 4'hf;
    // offsets read right after reset
    logic [11:0] ra [5] = '{12'h110, 12'h114, 12'h118, 12'h120, 12'h1fc};
    logic ack_o, req_v, dec_valid_o;
    prf_pkg::prf_src_s src = '0, req_src, s;
    prf_pkg::prf_decision_s dec_o;
    int n_mismatch = 0, n_compared = 0, k;
    // free-running 50 MHz clock
    always #10 clk_i = ~clk_i;
    prf_filter i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .req_valid_i(req_v), .req_src_i(req_src),
        .local_bus_id_i(10'h015), .dec_valid_o(dec_valid_o), .dec_o(dec_o),
        .phys_hi_o(phys_hi_o));
    prf_node_model i_node (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .src_i(src),
        .req_valid_o(req_v), .req_src_o(req_src));
    task tally_and_finish;
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task cmp_dec(input prf_pkg::prf_decision_s e, input prf_pkg::prf_decision_s g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED dec_o exp %h got %h", e, g);
        end
    endtask
    // one classic wishbone cycle, held until ack
    task wb(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, v, sl};
        n = 0;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        if (n >= 20)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // expected routing from the async high and physical low filter models
    function prf_pkg::prf_route_e exp_route(input prf_pkg::prf_src_s x, input logic [31:0] f);
        if (x.bus_id != 10'h015 && x.bus_id != 10'h3ff)
            return f[31] ? prf_pkg::PRF_TO_PHYSICAL : prf_pkg::PRF_NO_ACK;
        if (x.node_id == 6'h3f) return prf_pkg::PRF_NO_ACK;
        if (x.node_id[5] && !a[x.node_id[4:0]]) return prf_pkg::PRF_NO_ACK;
        if (x.node_id[5] ? f[x.node_id[4:0]] : l[x.node_id[4:0]])
            return prf_pkg::PRF_TO_PHYSICAL;
        return prf_pkg::PRF_TO_ASYNC;
    endfunction
    // one request through the node model, then its decision
    task send_req(input prf_pkg::prf_src_s x);
        int n;
        @(posedge clk_i);
        send <= 1'b1;
        src <= x;
        @(posedge clk_i);
        send <= 1'b0;
        n = 0;
        while (dec_valid_o !== 1'b1 && n < 8)
        begin
            @(negedge clk_i);
            n++;
        end
        cmp_dec({exp_route(x, m), x}, dec_o);
        if (n >= 8)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    initial
    begin
        void'($urandom(32'h348c));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        m = 32'h0;
        wb(1'b1, 12'h120, 32'hffff_ffff, rd);
        foreach (ra[i])
        begin
            wb(1'b0, ra[i], 32'h0, rd);
            cmp_word("reset read", 32'h0, rd);
        end
        wb(1'b1, 12'h100, 32'hffff_ffff, rd);
        wb(1'b1, 12'h108, 32'hffff_ffff, rd);
        for (int i = 0; i < 150; i++)
        begin
            // corner: close async high nodes 32-47, open every other low node
            if (i == 100)
            begin
                sl = 4'hf;
                wb(1'b1, 12'h104, 32'h0000_ffff, rd);
                wb(1'b1, 12'h118, 32'h5555_5555, rd);
                a = 32'hffff_0000;
                l = 32'h5555_5555;
                wb(1'b0, 12'h11c, 32'h0, rd);
                cmp_word("low filter read", l, rd);
            end
            sl = (i % 4 == 3) ? 4'($urandom) : 4'hf;
            d = (i == 0) ? 32'hc000_0001 : $urandom;
            k = $urandom % 3;
            dm = d & {{8{sl[3]}}, {8{sl[2]}}, {8{sl[1]}}, {8{sl[0]}}};
            if (k == 0) m = m | dm;
            if (k == 1) m = m & ~dm;
            wb(k < 2, (k == 1) ? 12'h114 : 12'h110, d, rd);
            wb(1'b0, (i % 2) ? 12'h114 : 12'h110, 32'h0, rd);
            cmp_word("filter read", m, rd);
            cmp_word("phys_hi_o", m, phys_hi_o);
            s.node_id = (i < 3) ? 6'h3e + i[5:0] : 6'($urandom % 64);
            k = $urandom % 3;
            s.bus_id = (k == 0) ? 10'h015 : (k == 1) ? 10'h3ff : 10'(10'h100 + $urandom % 512);
            send_req(s);
        end
        tally_and_finish();
    end
endmodule // physical_request_filter_high_tb_top
